// file: core/srbc_pkg.sv
// Constants, types and register map of the shift register bus comparator.
// Function
// - Eight-bit register shifts LSB to MSB, cascade in to cascade out.
// - All serial and parallel data enter only on rising shift clock edges.
// - Two select lines choose shift, load, hold or read out.
// - Bidirectional eight-line bus loads the register and carries it out.
// - Serial in and out path is separate from the parallel bus.
// - Stored byte is compared against the byte on the bus.
// - Three active-high open-collector outputs: equal, greater, less.
// - Status gate deasserted releases all three result outputs.
// - Compare kind selects unsigned magnitude or two's-complement compare.
// - Linking pins let byte-wide devices chain into wider comparisons.
// - Select decode: 00 hold, 01 read, 10 shift, 11 load (low line first).
// - Bus drivers enabled only in read; released in every other operation.
// - Greater and less stay released while cascade input is low.
// - Outside shift, cascade output is high when cascade input is high and register equals bus, else low; in shift it carries the MSB.
package srbc_pkg;

	localparam int DATA_W = 8;
	localparam int AXI_AW = 4;
	localparam int AXI_DW = 32;

	// Register byte offsets.
	localparam logic [AXI_AW-1:0] CTRL_OFFSET   = 4'h0;
	localparam logic [AXI_AW-1:0] STATUS_OFFSET = 4'h4;

	// Control register fields.
	localparam int CTRL_LO_BIT   = 0;
	localparam int CTRL_HI_BIT   = 1;
	localparam int CTRL_GATE_BIT = 2;
	localparam int CTRL_KIND_BIT = 3;
	localparam int CTRL_W        = 4;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h4;

	// Status register fields.
	localparam int STAT_DATA_LSB  = 0;
	localparam int STAT_MATCH_BIT = 8;
	localparam int STAT_ABOVE_BIT = 9;
	localparam int STAT_BELOW_BIT = 10;
	localparam int STAT_CASC_BIT  = 11;

	localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
	localparam logic [1:0]        RESP_OKAY  = 2'h0;
	localparam logic [1:0]        RESP_DECERR = 2'h3;

	// Operation code is {op_select_hi, op_select_lo}.
	typedef enum logic [1:0] {
		OP_HOLD  = 2'b00,
		OP_SHIFT = 2'b01,
		OP_READ  = 2'b10,
		OP_LOAD  = 2'b11
	} srbc_op_t;

	// One bit per open-collector result pin.
	typedef struct packed {
		logic match;
		logic above;
		logic below;
	} srbc_flags_t;

endpackage : srbc_pkg

// file: core/srbc_compare.sv
// Byte comparator with unsigned or two's-complement ordering.
module srbc_compare
	import srbc_pkg::*;
#(
	parameter int WIDTH = DATA_W
) (
	// Operands
	input  wire logic [WIDTH-1:0] stored,
	input  wire logic [WIDTH-1:0] bus_val,
	input  wire logic             signed_kind,
	// Results
	output logic                  eq,
	output logic                  gt,
	output logic                  lt
);
	import srbc_pkg::*;

	logic [WIDTH-1:0] stored_key;
	logic [WIDTH-1:0] bus_key;

	// Flipping the sign bit maps two's-complement order onto unsigned order.
	assign stored_key = {stored[WIDTH-1] ^ signed_kind, stored[WIDTH-2:0]};
	assign bus_key    = {bus_val[WIDTH-1] ^ signed_kind, bus_val[WIDTH-2:0]};
	assign eq = (stored == bus_val);
	assign gt = (stored_key > bus_key);
	assign lt = (stored_key < bus_key);

endmodule : srbc_compare

// file: core/srbc_top.sv
// Shift register bus comparator with its AXI4-Lite control slave.
//
// Chosen here: the AXI4-Lite slave port and the placing of the registers.
module srbc_top
	import srbc_pkg::*;
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write address
	input  wire logic [AXI_AW-1:0]     s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [AXI_DW-1:0]     s_axi_wdata,
	input  wire logic [AXI_DW/8-1:0]   s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [AXI_AW-1:0]     s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	// AXI4-Lite read data
	output logic [AXI_DW-1:0]          s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// Shift clock and cascade link
	input  wire logic                  shift_clock,
	input  wire logic                  cascade_in,
	output logic                       cascade_out,
	// Parallel bus pin
	input  wire logic [DATA_W-1:0]     bus_in,
	output logic [DATA_W-1:0]          bus_out,
	output logic                       bus_oe,
	// Open-collector result pins
	input  wire srbc_flags_t           flag_in,
	output srbc_flags_t                flag_out,
	output srbc_flags_t                flag_oe
);
	import srbc_pkg::*;

	logic [CTRL_W-1:0] ctrl_reg;
	logic [CTRL_W-1:0] ctrl_next;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] data_next;
	logic              shift_clock_prev_reg;
	logic              bus_oe_reg;
	logic              bus_oe_next;

	logic              awready_reg;
	logic              wready_reg;
	logic              bvalid_reg;
	logic [1:0]        bresp_reg;
	logic [AXI_AW-1:0] aw_addr_reg;
	logic [AXI_DW-1:0] w_data_reg;
	logic [AXI_DW/8-1:0] w_strb_reg;
	logic              arready_reg;
	logic              rvalid_reg;
	logic [AXI_DW-1:0] rdata_reg;
	logic [1:0]        rresp_reg;

	// Decode and selection.
	srbc_op_t          op;
	srbc_op_t          op_next;
	logic              clk_edge;
	logic              gate_on;
	logic              cmp_eq;
	logic              cmp_gt;
	logic              cmp_lt;
	logic              aw_take;
	logic              w_take;
	logic              ar_take;
	logic              do_write;
	logic              b_done;
	logic              r_done;
	logic              wr_hit_ctrl;
	logic              wr_hit_any;
	logic              rd_hit_ctrl;
	logic              rd_hit_stat;
	logic [AXI_DW-1:0] ctrl_word;
	logic [AXI_DW-1:0] stat_word;
	logic [AXI_DW-1:0] rd_word;

	function automatic logic word_hit(
		input logic [AXI_AW-1:0] addr,
		input logic [AXI_AW-1:0] offset
	);
		word_hit = (addr[AXI_AW-1:2] == offset[AXI_AW-1:2]);
	endfunction : word_hit

	assign op       = srbc_op_t'({ctrl_reg[CTRL_HI_BIT],
		ctrl_reg[CTRL_LO_BIT]});
	assign op_next  = srbc_op_t'({ctrl_next[CTRL_HI_BIT],
		ctrl_next[CTRL_LO_BIT]});
	// The shift clock is sampled as a synchronous level; its rising edge is
	// found against the last sample, so data move once per edge.
	assign clk_edge = shift_clock & ~shift_clock_prev_reg;
	assign gate_on  = ~ctrl_reg[CTRL_GATE_BIT];

	srbc_compare #(
		.WIDTH (DATA_W)
	) u_compare (
		.stored      (data_reg),
		.bus_val     (bus_in),
		.signed_kind (ctrl_reg[CTRL_KIND_BIT]),
		.eq          (cmp_eq),
		.gt          (cmp_gt),
		.lt          (cmp_lt)
	);

	// Register datapath.
	always_comb begin
		data_next = data_reg;
		if (clk_edge) begin
			case (op)
				OP_SHIFT: data_next = {data_reg[DATA_W-2:0], cascade_in};
				OP_LOAD:  data_next = bus_in;
				OP_HOLD:  data_next = data_reg;
				OP_READ:  data_next = data_reg;
				default:  data_next = data_reg;
			endcase
		end
	end

	// Result pins are never driven high: a true result releases the pin,
	// a false one pulls it low, so chained devices can share one wire.
	assign flag_out = '0;
	assign flag_oe.match = gate_on & ~cmp_eq;
	// Greater and less are only pulled low when this byte holds priority.
	assign flag_oe.above = gate_on & cascade_in & ~cmp_gt;
	assign flag_oe.below = gate_on & cascade_in & ~cmp_lt;
	// In shift mode the link carries serial data, otherwise the equal
	// status that hands priority down the chain.
	assign cascade_out = (op == OP_SHIFT) ? data_reg[DATA_W-1]
		: (cascade_in & cmp_eq);

	assign bus_out     = data_reg;
	assign bus_oe      = bus_oe_reg;
	assign bus_oe_next = (op_next == OP_READ);

	// AXI4-Lite handshakes.
	assign aw_take  = s_axi_awvalid & awready_reg;
	assign w_take   = s_axi_wvalid & wready_reg;
	assign ar_take  = s_axi_arvalid & arready_reg;
	assign do_write = ~awready_reg & ~wready_reg & ~bvalid_reg;
	assign b_done   = bvalid_reg & s_axi_bready;
	assign r_done   = rvalid_reg & s_axi_rready;

	assign wr_hit_ctrl = word_hit(aw_addr_reg, CTRL_OFFSET);
	assign wr_hit_any  = wr_hit_ctrl | word_hit(aw_addr_reg, STATUS_OFFSET);
	assign rd_hit_ctrl = word_hit(s_axi_araddr, CTRL_OFFSET);
	assign rd_hit_stat = word_hit(s_axi_araddr, STATUS_OFFSET);

	// Only lane zero carries control bits; writes to status are ignored.
	assign ctrl_next = (do_write & wr_hit_ctrl & w_strb_reg[0])
		? w_data_reg[CTRL_W-1:0] : ctrl_reg;

	assign ctrl_word = {{(AXI_DW-CTRL_W){1'b0}}, ctrl_reg};
	assign stat_word = {{(AXI_DW-STAT_CASC_BIT-1){1'b0}}, cascade_out,
		flag_in.below, flag_in.above, flag_in.match, data_reg};
	assign rd_word = rd_hit_ctrl ? ctrl_word
		: (rd_hit_stat ? stat_word : '0);

	assign s_axi_awready = awready_reg;
	assign s_axi_wready  = wready_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rdata   = rdata_reg;
	assign s_axi_rresp   = rresp_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg             <= CTRL_RESET;
			data_reg             <= DATA_RESET;
			shift_clock_prev_reg <= 1'b0;
			bus_oe_reg           <= 1'b0;
		end else begin
			ctrl_reg             <= ctrl_next;
			data_reg             <= data_next;
			shift_clock_prev_reg <= shift_clock;
			bus_oe_reg           <= bus_oe_next;
		end
	end

	// Address and data are parked until both arrive; ready stays low until
	// the response is accepted, so one write at a time is in flight.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_reg <= 1'b1;
			wready_reg  <= 1'b1;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			aw_addr_reg <= '0;
			w_data_reg  <= '0;
			w_strb_reg  <= '0;
		end else begin
			if (aw_take) begin
				awready_reg <= 1'b0;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (w_take) begin
				wready_reg <= 1'b0;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				bvalid_reg <= 1'b1;
				bresp_reg  <= wr_hit_any ? RESP_OKAY : RESP_DECERR;
			end
			if (b_done) begin
				bvalid_reg  <= 1'b0;
				awready_reg <= 1'b1;
				wready_reg  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_reg <= 1'b1;
			rvalid_reg  <= 1'b0;
			rdata_reg   <= '0;
			rresp_reg   <= RESP_OKAY;
		end else begin
			if (ar_take) begin
				arready_reg <= 1'b0;
				rvalid_reg  <= 1'b1;
				rdata_reg   <= rd_word;
				rresp_reg   <= (rd_hit_ctrl | rd_hit_stat)
					? RESP_OKAY : RESP_DECERR;
			end
			if (r_done) begin
				rvalid_reg  <= 1'b0;
				arready_reg <= 1'b1;
			end
		end
	end

	// Checks.
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_shift_step: assert property (
		clk_edge && op == OP_SHIFT |=> data_reg ==
			{$past(data_reg[DATA_W-2:0]), $past(cascade_in)})
		else $error("Shift did not move one place toward the MSB.");

	a_load_from_bus: assert property (
		clk_edge && op == OP_LOAD |=> data_reg == $past(bus_in))
		else $error("Load did not capture the bus byte.");

	a_edge_only: assert property (
		!clk_edge |=> $stable(data_reg))
		else $error("Register changed without a shift clock edge.");

	a_hold_read_keep: assert property (
		clk_edge && (op == OP_HOLD || op == OP_READ) |=> $stable(data_reg))
		else $error("Hold or read altered the register.");

	a_bus_drive_read: assert property (
		bus_oe == (op == OP_READ) && (!bus_oe || bus_out == data_reg))
		else $error("Bus drivers enabled outside read mode.");

	a_gate_release: assert property (
		ctrl_reg[CTRL_GATE_BIT] |-> flag_oe == '0 && flag_out == '0)
		else $error("Result pins driven while status gate is off.");

	a_priority_gtlt: assert property (
		!cascade_in |-> !flag_oe.above && !flag_oe.below)
		else $error("Greater or less driven without priority.");

	a_match_flag: assert property (
		gate_on |-> flag_oe.match == (data_reg != bus_in))
		else $error("Equal pin does not follow the comparison.");

	a_cascade_equal: assert property (
		op != OP_SHIFT |-> cascade_out == (cascade_in && data_reg == bus_in))
		else $error("Cascade output does not report equality.");

	a_signed_order: assert property (
		gate_on && cascade_in && ctrl_reg[CTRL_KIND_BIT] &&
		data_reg[DATA_W-1] && !bus_in[DATA_W-1]
		|-> flag_oe.above && !flag_oe.below)
		else $error("Negative stored byte not reported as less.");

	a_write_answer: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("Write response late.");

	a_read_answer: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("Read response late.");

	c_shift: cover property (clk_edge && op == OP_SHIFT);
	c_load: cover property (clk_edge && op == OP_LOAD);
	c_read_drive: cover property (bus_oe && gate_on);
	c_chain_equal: cover property (cascade_in && cascade_out && gate_on);

endmodule : srbc_top

// file: verif/srbc_host_model.sv
// Host data bus and chained neighbour device facing the comparator pins.
module srbc_host_model
	import srbc_pkg::*;
(
	// Clock
	input  wire logic              aclk,
	// Host and neighbour controls
	input  wire logic              host_en,
	input  wire logic [DATA_W-1:0] host_data,
	input  wire srbc_flags_t       nb_oe,
	// Device pins
	input  wire logic [DATA_W-1:0] bus_out,
	input  wire logic              bus_oe,
	input  wire srbc_flags_t       flag_out,
	input  wire srbc_flags_t       flag_oe,
	output logic [DATA_W-1:0]      bus_in,
	output srbc_flags_t            flag_in
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [DATA_W-1:0] last_reg;
	// A floating bus shows the inverse of its last level, so stale data fails.
	assign bus_in = bus_oe ? bus_out : (host_en ? host_data : ~last_reg);
	always_ff @(posedge aclk) begin
		last_reg <= bus_in;
	end
	// Pull-up with wired-AND: any party pulling low wins.
	assign flag_in = srbc_flags_t'((~flag_oe | flag_out) & ~nb_oe);
endmodule : srbc_host_model

// file: verif/srbc_top_tb.sv
// Self-checking bench for the shift register bus comparator.
module srbc_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import srbc_pkg::*;
	localparam int TMO = 5000;
	logic aclk, aresetn, shift_clock, cascade_in, cascade_out, host_en;
	logic [AXI_AW-1:0] s_axi_awaddr, s_axi_araddr;
	logic [AXI_DW-1:0] s_axi_wdata, s_axi_rdata;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, bus_oe;
	logic [DATA_W-1:0] bus_in, bus_out, host_data;
	srbc_flags_t flag_in, flag_out, flag_oe, nb_oe;
	int n_fail, checked, cycles;

	srbc_top u_srbc_top (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .shift_clock, .cascade_in,
		.cascade_out, .bus_in, .bus_out, .bus_oe, .flag_in, .flag_out,
		.flag_oe);
	srbc_host_model u_srbc_host_model (.aclk, .host_en, .host_data, .nb_oe,
		.bus_out, .bus_oe, .flag_out, .flag_oe, .bus_in, .flag_in);

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", what, e, g);
			n_fail++;
		end
	endtask : chk

	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic done;
		done = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!done) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) begin
				chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
				s_axi_bready <= 1'b0;
				done = 1'b1;
			end
		end
	endtask : wr

	task automatic rd(input logic [3:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		chk("rdata", e, s_axi_rdata & m);
		chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
		s_axi_rready <= 1'b0;
	endtask : rd

	// High for three cycles: a held level must still give a single edge.
	task automatic pulse;
		@(posedge aclk);
		shift_clock <= 1'b1;
		repeat (3) @(posedge aclk);
		shift_clock <= 1'b0;
		@(posedge aclk);
	endtask : pulse

	task automatic t_reset;
		rd(CTRL_OFFSET, 32'hffffffff, 32'h4, RESP_OKAY);
		rd(STATUS_OFFSET, 32'hffffffff, 32'h700, RESP_OKAY);
		rd(4'h8, 32'hffffffff, 32'h0, RESP_DECERR);
		wr(4'hc, 32'h0, RESP_DECERR);
		wr(STATUS_OFFSET, 32'hff, RESP_OKAY);
		rd(CTRL_OFFSET, 32'hffffffff, 32'h4, RESP_OKAY);
		$display("test reset done");
	endtask : t_reset

	task automatic t_load;
		wr(CTRL_OFFSET, 32'h7, RESP_OKAY);
		host_data <= 8'ha5;
		repeat (3) @(posedge aclk);
		rd(STATUS_OFFSET, 32'hff, 32'h0, RESP_OKAY);
		chk("bus_oe load", 32'h0, {31'h0, bus_oe});
		pulse();
		rd(STATUS_OFFSET, 32'hff, 32'ha5, RESP_OKAY);
		$display("test load done");
	endtask : t_load

	task automatic t_read;
		host_en <= 1'b0;
		wr(CTRL_OFFSET, 32'h2, RESP_OKAY);
		@(posedge aclk);
		chk("bus_oe read", 32'h1, {31'h0, bus_oe});
		chk("bus read", 32'ha5, {24'h0, bus_in});
		chk("read flags", 32'h7, 32'(flag_in));
		// A clock edge in read or hold mode must leave the byte alone.
		pulse();
		wr(CTRL_OFFSET, 32'h4, RESP_OKAY);
		host_en <= 1'b1;
		host_data <= 8'h3c;
		chk("bus_oe hold", 32'h0, {31'h0, bus_oe});
		pulse();
		rd(STATUS_OFFSET, 32'hff, 32'ha5, RESP_OKAY);
		$display("test read done");
	endtask : t_read

	task automatic t_shift;
		wr(CTRL_OFFSET, 32'h5, RESP_OKAY);
		cascade_in <= 1'b1;
		pulse();
		rd(STATUS_OFFSET, 32'hff, 32'h4b, RESP_OKAY);
		chk("serial out", 32'h0, {31'h0, cascade_out});
		cascade_in <= 1'b0;
		pulse();
		rd(STATUS_OFFSET, 32'hff, 32'h96, RESP_OKAY);
		chk("serial out", 32'h1, {31'h0, cascade_out});
		$display("test shift done");
	endtask : t_shift

	task automatic t_compare;
		logic [7:0] v [3] = '{8'h96, 8'h10, 8'hf0};
		logic [7:0] r;
		logic eq, gt, lt;
		r = 8'h96;
		for (int k = 0; k < 2; k++) begin
			wr(CTRL_OFFSET, k ? 32'h8 : 32'h0, RESP_OKAY);
			for (int i = 0; i < 3; i++) for (int c = 0; c < 2; c++) begin
				@(posedge aclk);
				host_data <= v[i];
				cascade_in <= c[0];
				#1;
				eq = (r == v[i]);
				gt = k ? ($signed(r) > $signed(v[i])) : (r > v[i]);
				lt = k ? ($signed(r) < $signed(v[i])) : (r < v[i]);
				chk("flags", {29'h0, eq, gt | !c, lt | !c}, 32'(flag_in));
				chk("cascade", {31'h0, eq & c[0]}, {31'h0, cascade_out});
			end
		end
		wr(CTRL_OFFSET, 32'h4, RESP_OKAY);
		@(posedge aclk);
		host_data <= 8'h10;
		#1;
		chk("gated", 32'h7, 32'(flag_in));
		@(posedge aclk);
		nb_oe <= 3'h4;
		#1;
		chk("wired", 32'h3, 32'(flag_in));
		$display("test compare done");
	endtask : t_compare

	task automatic complete_run;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == TMO) begin
			n_fail++;
			complete_run();
		end
	end

	initial begin
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, shift_clock, cascade_in} = '0;
		{aresetn, nb_oe, cycles, n_fail, checked} = '0;
		host_en = 1'b1;
		host_data = 8'h5a;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_load();
		t_read();
		t_shift();
		t_compare();
		complete_run();
	end
endmodule : srbc_top_tb
